// ===== inc/dtg_pkg.sv
// package: register map, fields, divider and tone constants for the dual-tone generator
package dtg_pkg;

    localparam int          AXI_ADDR_W        = 8;
    localparam int          AXI_DATA_W        = 32;

    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_TONE_FREQ_SEL = 6'h19;
    localparam logic [5:0]  IDX_TONE_OUT_CTRL = 6'h1a;
    localparam logic [5:0]  IDX_CLK_SRC_SEL   = 6'h29;
    localparam logic [5:0]  IDX_TONE_STATUS   = 6'h30;

    localparam logic [3:0]  RST_TONE_FREQ_SEL = 4'h0;
    localparam logic [2:0]  RST_TONE_OUT_CTRL = 3'h0;
    localparam logic [3:0]  RST_CLK_SRC_SEL   = 4'h0;

    // field positions
    localparam int          COL_SEL_LSB       = 2;
    localparam int          ROW_SEL_LSB       = 0;
    localparam int          CTRL_LSB          = 1;
    localparam int          OSC_CODE_LSB      = 0;
    localparam int          STAT_ACTIVE_BIT   = 0;
    localparam int          STAT_ROW_SLOT_LSB = 1;
    localparam int          STAT_COL_SLOT_LSB = 6;

    localparam logic [1:0]  AXI_OKAY          = 2'h0;
    localparam logic [1:0]  AXI_SLVERR        = 2'h2;

    // oscillator codes and the divisor that brings each to the base rate
    localparam logic [1:0]  OSC_400K          = 2'h0;
    localparam logic [1:0]  OSC_800K          = 2'h1;
    localparam logic [1:0]  OSC_2M            = 2'h2;
    localparam logic [1:0]  OSC_4M            = 2'h3;
    localparam logic [3:0]  DIV_BY_1          = 4'h1;
    localparam logic [3:0]  DIV_BY_2          = 4'h2;
    localparam logic [3:0]  DIV_BY_5          = 4'h5;
    localparam logic [3:0]  DIV_BY_10         = 4'ha;
    localparam int          BASE_FREQ_KHZ     = 400;

    // sine period in base ticks: 400 kHz / tone
    localparam int          SLOTS             = 32;
    localparam int          PERIOD_W          = 10;
    localparam logic [9:0]  ROW_PERIOD_1      = 10'd576;
    localparam logic [9:0]  ROW_PERIOD_2      = 10'd520;
    localparam logic [9:0]  ROW_PERIOD_3      = 10'd470;
    localparam logic [9:0]  ROW_PERIOD_4      = 10'd426;
    localparam logic [9:0]  COL_PERIOD_1      = 10'd330;
    localparam logic [9:0]  COL_PERIOD_2      = 10'd300;
    localparam logic [9:0]  COL_PERIOD_3      = 10'd270;
    localparam logic [9:0]  COL_PERIOD_4      = 10'd244;
    localparam logic [9:0]  SLOT_STEP         = 10'd32;

    localparam int          DAC_W             = 8;
    localparam logic [7:0]  DAC_OFF           = 8'h00;
    localparam logic [7:0]  SINE_LUT [0:31]   = '{
        8'h80, 8'h99, 8'hb1, 8'hc7, 8'hda, 8'hea, 8'hf5, 8'hfd,
        8'hff, 8'hfd, 8'hf5, 8'hea, 8'hda, 8'hc7, 8'hb1, 8'h99,
        8'h80, 8'h67, 8'h4f, 8'h39, 8'h26, 8'h16, 8'h0b, 8'h03,
        8'h01, 8'h03, 8'h0b, 8'h16, 8'h26, 8'h39, 8'h4f, 8'h67};

    typedef struct packed {
        logic       colEn;
        logic       rowEn;
        logic       circEn;
    } dtg_ctrl_type;

    typedef struct packed {
        logic [1:0] colSel;
        logic [1:0] rowSel;
    } dtg_mode_type;

    function automatic logic [9:0] dtg_row_period(input logic [1:0] sel);
        case (sel)
            2'h0:    return ROW_PERIOD_1;
            2'h1:    return ROW_PERIOD_2;
            2'h2:    return ROW_PERIOD_3;
            default: return ROW_PERIOD_4;
        endcase
    endfunction

    function automatic logic [9:0] dtg_col_period(input logic [1:0] sel);
        case (sel)
            2'h0:    return COL_PERIOD_1;
            2'h1:    return COL_PERIOD_2;
            2'h2:    return COL_PERIOD_3;
            default: return COL_PERIOD_4;
        endcase
    endfunction

    function automatic logic [3:0] dtg_osc_div(input logic [1:0] code);
        case (code)
            OSC_400K: return DIV_BY_1;
            OSC_800K: return DIV_BY_2;
            OSC_2M:   return DIV_BY_5;
            default:  return DIV_BY_10;
        endcase
    endfunction

endpackage

// ===== rtl/dtg_prescaler.sv
// oscillator pre-divider: picks the divided clock matching the oscillator, as an enable pulse
`timescale 1ns/1ps
`default_nettype none
module dtg_prescaler
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       oscClk,
    input  wire logic [1:0] oscCode,
    output logic            baseTick
);
    import dtg_pkg::*;

    logic       sync1_r;
    logic       sync2_r;
    logic       sync3_r;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [3:0] divisor;
    logic       oscEdge;

    assign oscEdge = sync2_r & ~sync3_r;
    assign divisor = dtg_osc_div(oscCode);

    always_comb
    begin
        cnt_nxt  = cnt_r;
        baseTick = 1'b0;
        if (oscEdge)
        begin
            // a wrong code only scales the rate, tones still run
            if (cnt_r >= divisor - 4'h1)
            begin
                cnt_nxt  = 4'h0;
                baseTick = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            cnt_r   <= 4'h0;
        end
        else
        begin
            sync1_r <= oscClk;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            cnt_r   <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/dtg_tone_channel.sv
// one tone group: fractional programmable divider feeding a 32-slot sine counter
`timescale 1ns/1ps
`default_nettype none
module dtg_tone_channel
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       enable,
    input  wire logic       baseTick,
    input  wire logic [9:0] period,
    output logic [4:0]      slot,
    output logic [7:0]      sample
);
    import dtg_pkg::*;

    logic [9:0]  acc_r;
    logic [9:0]  acc_nxt;
    logic [4:0]  slot_r;
    logic [4:0]  slot_nxt;
    logic [10:0] sum;

    // period ticks spread over 32 slots, so uneven slot lengths give exact pitch
    always_comb
    begin
        sum      = {1'b0, acc_r} + {1'b0, SLOT_STEP};
        acc_nxt  = acc_r;
        slot_nxt = slot_r;
        if (!enable)
        begin
            acc_nxt  = 10'h000;
            slot_nxt = 5'h00;
        end
        else if (baseTick)
        begin
            if (sum >= {1'b0, period})
            begin
                acc_nxt  = 10'(sum - {1'b0, period});
                slot_nxt = slot_r + 5'h01;
            end
            else
            begin
                acc_nxt = sum[9:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_r  <= 10'h000;
            slot_r <= 5'h00;
        end
        else
        begin
            acc_r  <= acc_nxt;
            slot_r <= slot_nxt;
        end
    end

    assign slot   = slot_r;
    assign sample = SINE_LUT[slot_r];
endmodule
`default_nettype wire

// ===== rtl/dtg_top.sv
// dual-tone generator top: AXI4-Lite registers, pre-divider, row and column tone channels
//
// Functional notes
// - oscillator divided by 1, 2, 5 or 10; one result drives tones.
// - two-bit code picks divider: 400k, 800k, 2M, 4M oscillator.
// - mismatched code still makes tones, pitch scaled by mismatch.
// - four-bit write-only tone select register, reset to zero.
// - upper pair picks column tone, lower pair row tone; 00 lowest.
// - tones equal synthesized values, e.g. 694.44, 1212.12, 1639.34 Hz.
// - output control register write-only, bits 3..1, reset zero.
// - bit 3 enables column output, bit 2 row output, independently.
// - bit 1 enables whole tone circuit.
// - each group has programmable divider clocking slot counter.
// - 32 slots per sine period, counter wraps once per period.
// - row and column sequences drive separate converter outputs.
// - four-bit write-only clock source register, reset zero.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module dtg_top
(
    input  wire logic                              clk,
    input  wire logic                              rst_b,
    input  wire logic                              oscClk,
    input  wire logic [dtg_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [dtg_pkg::AXI_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [dtg_pkg::AXI_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [dtg_pkg::AXI_DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    output logic [dtg_pkg::DAC_W-1:0]              row_tone_out,
    output logic [dtg_pkg::DAC_W-1:0]              column_tone_out
);
    import dtg_pkg::*;

    // write channel state
    logic                  awReady_r;
    logic                  awReady_nxt;
    logic                  wReady_r;
    logic                  wReady_nxt;
    logic                  awHeld_r;
    logic                  awHeld_nxt;
    logic                  wHeld_r;
    logic                  wHeld_nxt;
    logic [5:0]            awIdx_r;
    logic [5:0]            awIdx_nxt;
    logic [3:0]            wData_r;
    logic [3:0]            wData_nxt;
    logic                  wLane_r;
    logic                  wLane_nxt;
    logic                  bValid_r;
    logic                  bValid_nxt;
    logic [1:0]            bResp_r;
    logic [1:0]            bResp_nxt;
    logic                  doWrite;
    logic                  awHit;
    logic                  wHit;

    // read channel state
    logic                  arReady_r;
    logic                  arReady_nxt;
    logic                  rValid_r;
    logic                  rValid_nxt;
    logic [AXI_DATA_W-1:0] rData_r;
    logic [AXI_DATA_W-1:0] rData_nxt;
    logic [1:0]            rResp_r;
    logic [1:0]            rResp_nxt;

    // control registers
    dtg_mode_type          toneFreqSel_r;
    dtg_mode_type          toneFreqSel_nxt;
    dtg_ctrl_type          toneOutCtrl_r;
    dtg_ctrl_type          toneOutCtrl_nxt;
    logic [3:0]            clkSrcSel_r;
    logic [3:0]            clkSrcSel_nxt;

    // tone path
    logic                  baseTick;
    logic [4:0]            rowSlot;
    logic [4:0]            colSlot;
    logic [7:0]            rowSample;
    logic [7:0]            colSample;
    logic [DAC_W-1:0]      rowOut_r;
    logic [DAC_W-1:0]      rowOut_nxt;
    logic [DAC_W-1:0]      colOut_r;
    logic [DAC_W-1:0]      colOut_nxt;

    generate
        if (AXI_ADDR_W < 8)
        begin : g_addr_check
            $error("dtg_top: address width too small for the register map");
        end
    endgenerate

    // address and data may arrive in either order; response waits for both
    assign awHit   = s_axi_awvalid & awReady_r;
    assign wHit    = s_axi_wvalid & wReady_r;
    assign doWrite = (awHeld_r | awHit) & (wHeld_r | wHit) & ~bValid_r;

    always_comb
    begin
        awHeld_nxt      = awHeld_r | awHit;
        wHeld_nxt       = wHeld_r | wHit;
        awIdx_nxt       = awHit ? s_axi_awaddr[7:2] : awIdx_r;
        wData_nxt       = wHit ? s_axi_wdata[3:0] : wData_r;
        wLane_nxt       = wHit ? s_axi_wstrb[0] : wLane_r;
        bValid_nxt      = bValid_r & ~s_axi_bready;
        bResp_nxt       = bResp_r;
        toneFreqSel_nxt = toneFreqSel_r;
        toneOutCtrl_nxt = toneOutCtrl_r;
        clkSrcSel_nxt   = clkSrcSel_r;
        if (doWrite)
        begin
            awHeld_nxt = 1'b0;
            wHeld_nxt  = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt  = AXI_OKAY;
            // bits above the register width are dropped; lane 0 must be strobed
            case (awIdx_nxt)
                IDX_TONE_FREQ_SEL:
                begin
                    if (wLane_nxt)
                    begin
                        toneFreqSel_nxt = dtg_mode_type'(wData_nxt);
                    end
                end
                IDX_TONE_OUT_CTRL:
                begin
                    if (wLane_nxt)
                    begin
                        toneOutCtrl_nxt = dtg_ctrl_type'(wData_nxt[3:CTRL_LSB]);
                    end
                end
                IDX_CLK_SRC_SEL:
                begin
                    if (wLane_nxt)
                    begin
                        clkSrcSel_nxt = wData_nxt;
                    end
                end
                IDX_TONE_STATUS:
                begin
                    bResp_nxt = AXI_OKAY;
                end
                default:
                begin
                    bResp_nxt = AXI_SLVERR;
                end
            endcase
        end
        awReady_nxt = ~awHeld_nxt & ~bValid_nxt;
        wReady_nxt  = ~wHeld_nxt & ~bValid_nxt;
    end

    // write-only registers read as zero; status shows live tone state
    always_comb
    begin
        rValid_nxt = rValid_r & ~s_axi_rready;
        rData_nxt  = rData_r;
        rResp_nxt  = rResp_r;
        if (s_axi_arvalid & arReady_r)
        begin
            rValid_nxt = 1'b1;
            rData_nxt  = '0;
            rResp_nxt  = AXI_OKAY;
            case (s_axi_araddr[7:2])
                IDX_TONE_FREQ_SEL,
                IDX_TONE_OUT_CTRL,
                IDX_CLK_SRC_SEL:
                begin
                    rData_nxt = '0;
                end
                IDX_TONE_STATUS:
                begin
                    rData_nxt[STAT_ACTIVE_BIT]                        = toneOutCtrl_r.circEn;
                    rData_nxt[STAT_ROW_SLOT_LSB +: 5]                 = rowSlot;
                    rData_nxt[STAT_COL_SLOT_LSB +: 5]                 = colSlot;
                end
                default:
                begin
                    rResp_nxt = AXI_SLVERR;
                end
            endcase
        end
        arReady_nxt = ~rValid_nxt;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            awReady_r     <= 1'b0;
            wReady_r      <= 1'b0;
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            awIdx_r       <= 6'h00;
            wData_r       <= 4'h0;
            wLane_r       <= 1'b0;
            bValid_r      <= 1'b0;
            bResp_r       <= AXI_OKAY;
            arReady_r     <= 1'b0;
            rValid_r      <= 1'b0;
            rData_r       <= '0;
            rResp_r       <= AXI_OKAY;
            toneFreqSel_r <= dtg_mode_type'(RST_TONE_FREQ_SEL);
            toneOutCtrl_r <= dtg_ctrl_type'(RST_TONE_OUT_CTRL);
            clkSrcSel_r   <= RST_CLK_SRC_SEL;
        end
        else
        begin
            awReady_r     <= awReady_nxt;
            wReady_r      <= wReady_nxt;
            awHeld_r      <= awHeld_nxt;
            wHeld_r       <= wHeld_nxt;
            awIdx_r       <= awIdx_nxt;
            wData_r       <= wData_nxt;
            wLane_r       <= wLane_nxt;
            bValid_r      <= bValid_nxt;
            bResp_r       <= bResp_nxt;
            arReady_r     <= arReady_nxt;
            rValid_r      <= rValid_nxt;
            rData_r       <= rData_nxt;
            rResp_r       <= rResp_nxt;
            toneFreqSel_r <= toneFreqSel_nxt;
            toneOutCtrl_r <= toneOutCtrl_nxt;
            clkSrcSel_r   <= clkSrcSel_nxt;
        end
    end

    dtg_prescaler u_prescaler
    (
        .clk      (clk),
        .rst_b    (rst_b),
        .oscClk   (oscClk),
        .oscCode  (clkSrcSel_r[OSC_CODE_LSB +: 2]),
        .baseTick (baseTick)
    );

    // both groups stop and rewind while the circuit is disabled
    dtg_tone_channel u_row
    (
        .clk      (clk),
        .rst_b    (rst_b),
        .enable   (toneOutCtrl_r.circEn),
        .baseTick (baseTick),
        .period   (dtg_row_period(toneFreqSel_r.rowSel)),
        .slot     (rowSlot),
        .sample   (rowSample)
    );

    dtg_tone_channel u_col
    (
        .clk      (clk),
        .rst_b    (rst_b),
        .enable   (toneOutCtrl_r.circEn),
        .baseTick (baseTick),
        .period   (dtg_col_period(toneFreqSel_r.colSel)),
        .slot     (colSlot),
        .sample   (colSample)
    );

    always_comb
    begin
        rowOut_nxt = DAC_OFF;
        colOut_nxt = DAC_OFF;
        if (toneOutCtrl_r.circEn && toneOutCtrl_r.rowEn)
        begin
            rowOut_nxt = rowSample;
        end
        if (toneOutCtrl_r.circEn && toneOutCtrl_r.colEn)
        begin
            colOut_nxt = colSample;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rowOut_r <= DAC_OFF;
            colOut_r <= DAC_OFF;
        end
        else
        begin
            rowOut_r <= rowOut_nxt;
            colOut_r <= colOut_nxt;
        end
    end

    assign s_axi_awready   = awReady_r;
    assign s_axi_wready    = wReady_r;
    assign s_axi_bvalid    = bValid_r;
    assign s_axi_bresp     = bResp_r;
    assign s_axi_arready   = arReady_r;
    assign s_axi_rvalid    = rValid_r;
    assign s_axi_rdata     = rData_r;
    assign s_axi_rresp     = rResp_r;
    assign row_tone_out    = rowOut_r;
    assign column_tone_out = colOut_r;
endmodule
`default_nettype wire

// ===== verif/dtg_top_monitor.sv
// checker: bus handshakes and tone slot timing at the generator's ports
`timescale 1ns/1ps
`default_nettype none
module dtg_top_monitor
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  row_tone_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped while stalled");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed while stalled");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered next cycle");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    a_write_reopen: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not reopened");
    a_read_reopen: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");
    a_error_data: assert property (
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    // a slot lasts many clocks; only a disable may cut it short
    a_slot_hold: assert property (
        $changed(row_tone_out) && $past(row_tone_out) != 8'h00 && row_tone_out != 8'h00
        |=> (row_tone_out == $past(row_tone_out) || row_tone_out == 8'h00) [*4])
        else $error("row sample changed within a slot");
endmodule

bind dtg_top dtg_top_monitor dtg_top_monitor_i (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .row_tone_out);
`default_nettype wire

// ===== verif/dtg_line_model.sv
// far side: line receiver measuring one tone's sine period in clocks
`timescale 1ns/1ps
`default_nettype none
module dtg_line_model
    import dtg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       clr,
    input  wire logic [7:0] tone,
    output logic [15:0]     per,
    output logic [1:0]      wraps,
    output logic            act
);
    logic [15:0] cnt;
    logic [7:0]  prev;
    // first interval after clr may mix old and new pitch, so read after two wraps
    always @(posedge clk)
    begin
        prev <= tone;
        cnt  <= cnt + 16'h1;
        if (tone != 8'h00)
            act <= 1'b1;
        if (prev == SINE_LUT[31] && tone == SINE_LUT[0])
        begin
            per <= cnt;
            cnt <= 16'h1;
            if (wraps != 2'h3)
                wraps <= wraps + 2'h1;
        end
        if (clr)
        begin
            wraps <= 2'h0;
            act   <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verif/dtg_top_tb.sv
// testbench: register bus, pitch, clock code and enables of the tone generator
`timescale 1ns/1ps
`default_nettype none
module dtg_top_tb;
    import dtg_pkg::*;
    logic        clk, rst_b, oscClk, clr, rowAct, colAct;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, row_tone_out, column_tone_out;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, rowWraps, colWraps;
    logic [15:0] rowPer, colPer;
    int          n_fail = 0;
    int          samples_checked = 0;
    localparam logic [7:0] ADDR_SEL  = {IDX_TONE_FREQ_SEL, 2'b00};
    localparam logic [7:0] ADDR_CTL  = {IDX_TONE_OUT_CTRL, 2'b00};
    localparam logic [7:0] ADDR_CLK  = {IDX_CLK_SRC_SEL, 2'b00};
    localparam logic [7:0] ADDR_STAT = {IDX_TONE_STATUS, 2'b00};

    dtg_top dtg_top_i (.clk, .rst_b, .oscClk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .row_tone_out, .column_tone_out);
    dtg_line_model rowRx (.clk, .clr, .tone(row_tone_out), .per(rowPer), .wraps(rowWraps), .act(rowAct));
    dtg_line_model colRx (.clk, .clr, .tone(column_tone_out), .per(colPer), .wraps(colWraps), .act(colAct));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // oscillator: four clocks a cycle, phase unrelated to clk
    initial
    begin
        oscClk = 1'b0;
        #7;
        forever #80 oscClk = ~oscClk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic listen(input bit both);
        int n = 0;
        repeat (20) @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        @(posedge clk);
        while ((colWraps < 2 || (both && rowWraps < 2)) && n < 40000)
        begin
            @(posedge clk);
            n++;
        end
        chk(32'(n < 40000), 32'h1);
    endtask

    task automatic t_reset;
        chk(32'(row_tone_out), 32'h0);
        rd(ADDR_STAT);
        chk(d, 32'h0);
        wr(ADDR_CTL, 32'he);
        listen(1'b1);
        chk(32'(rowPer), 32'(ROW_PERIOD_1) * 4);
        chk(32'(colPer), 32'(COL_PERIOD_1) * 4);
        $display("t_reset done");
    endtask

    task automatic t_bus;
        wr(8'h00, 32'hf);
        chk(32'(r), 32'(AXI_SLVERR));
        rd(8'h00);
        chk({d[29:0], r}, 32'(AXI_SLVERR));
        rd(ADDR_SEL);
        chk({d[29:0], r}, 32'(AXI_OKAY));
        wr(ADDR_STAT, 32'h0);
        chk(32'(r), 32'(AXI_OKAY));
        $display("t_bus done");
    endtask

    // row and column codes run opposite ways so a swapped field shows
    task automatic t_pitch;
        logic [9:0] rp [4];
        logic [9:0] cp [4];
        rp = '{ROW_PERIOD_1, ROW_PERIOD_2, ROW_PERIOD_3, ROW_PERIOD_4};
        cp = '{COL_PERIOD_1, COL_PERIOD_2, COL_PERIOD_3, COL_PERIOD_4};
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_SEL, 32'(i * 4 + 3 - i));
            listen(1'b1);
            chk(32'(rowPer), 32'(rp[3 - i]) * 4);
            chk(32'(colPer), 32'(cp[i]) * 4);
        end
        $display("t_pitch done");
    endtask

    // oscillator fixed, code changed: pitch falls by the divide ratio
    task automatic t_clkcode;
        int dv [3];
        dv = '{2, 5, 10};
        wr(ADDR_SEL, 32'hf);
        for (int c = 1; c < 4; c++)
        begin
            wr(ADDR_CLK, 32'(c * 5));
            listen(1'b0);
            chk(32'(colPer), 32'(COL_PERIOD_4) * 4 * dv[c - 1]);
        end
        wr(ADDR_CLK, 32'h0);
        $display("t_clkcode done");
    endtask

    task automatic t_enables;
        logic [3:0] ctl [4];
        logic [1:0] ex [4];
        ctl = '{4'ha, 4'h6, 4'hc, 4'h2};
        ex = '{2'b01, 2'b10, 2'b00, 2'b00};
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR_CTL, 32'(ctl[k]));
            rd(ADDR_STAT);
            chk(32'(d[0]), 32'(ctl[k][1]));
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (300) @(posedge clk);
            chk(32'({rowAct, colAct}), 32'(ex[k]));
        end
        $display("t_enables done");
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        rst_b = 1'b0;
        clr = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset;
        t_bus;
        t_pitch;
        t_clkcode;
        t_enables;
        test_done;
    end

    initial
    begin
        repeat (90000) @(posedge clk);
        n_fail++;
        $display("ERROR at %0t: watchdog expired", $time);
        test_done;
    end
endmodule
`default_nettype wire
